// File: usb_ep_pkg.sv
// package: register map, reset values and carriers for the endpoint counter block
`default_nettype none
package usb_ep_pkg;

    // ========================================
    // register byte addresses
    localparam logic [7:0] setup_rx_count_low_addr = 8'h00;
    localparam logic [7:0] setup_rx_count_high_addr = 8'h04;
    localparam logic [7:0] ep0_out_count_low_addr = 8'h08;
    localparam logic [7:0] ep0_out_count_high_addr = 8'h0c;
    localparam logic [7:0] ep0_in_count_low_addr = 8'h10;
    localparam logic [7:0] ep0_in_count_high_addr = 8'h14;
    localparam logic [7:0] ep1_count_low_addr = 8'h18;
    localparam logic [7:0] ep1_count_high_addr = 8'h1c;
    localparam logic [7:0] ep2_count_low_addr = 8'h20;
    localparam logic [7:0] ep2_count_high_addr = 8'h24;
    localparam logic [7:0] ep3_count_low_addr = 8'h28;
    localparam logic [7:0] ep3_count_high_addr = 8'h2c;
    localparam logic [7:0] endpoint_direction_addr = 8'h30;
    localparam logic [7:0] packet_tx_arm_addr = 8'h34;
    localparam logic [7:0] fn_control_addr = 8'h38;

    // ========================================
    // counter indices and reset values
    localparam int num_counters = 6;
    localparam int idx_setup_rx = 0;
    localparam int idx_ep0_out = 1;
    localparam int idx_ep0_in = 2;
    localparam int idx_ep1 = 3;
    localparam int idx_ep2 = 4;
    localparam int idx_ep3 = 5;
    localparam logic [9:0] setup_rx_count_reset = 10'h000;
    localparam logic [9:0] ep0_out_count_reset = 10'h000;
    localparam logic [9:0] ep0_in_count_reset = 10'h010;
    localparam logic [9:0] ep1_count_reset = 10'h010;
    localparam logic [9:0] ep2_count_reset = 10'h010;
    localparam logic [9:0] ep3_count_reset = 10'h008;
    localparam logic [9:0] setup_ep0_in_count = 10'h010;

    // ========================================
    // direction and arm register fields
    localparam logic [7:0] endpoint_direction_reset = 8'h3c;
    localparam logic [7:0] endpoint_direction_mask = 8'h7c;
    localparam logic [7:0] packet_tx_arm_mask = 8'h3e;
    localparam int ep1_direction_bit = 2;
    localparam int ep2_direction_bit = 3;
    localparam int ep3_direction_bit = 4;
    localparam int ep4_direction_bit = 5;
    localparam int ep5_direction_bit = 6;
    localparam int ep0_in_tx_arm_bit = 1;
    localparam int ep1_tx_arm_bit = 2;
    localparam int ep2_tx_arm_bit = 3;
    localparam int ep3_tx_arm_bit = 4;
    localparam int ep4_tx_arm_bit = 5;
    localparam int fn_soft_reset_bit = 0;

    // ========================================
    // carriers
    typedef enum logic [1:0] {
        bus_idle = 2'b00,
        bus_wresp = 2'b01,
        bus_rresp = 2'b10
    } bus_state_e;

    // core event: which counter, how many bytes
    typedef struct packed {
        logic valid;
        logic [2:0] index;
        logic [9:0] bytes;
    } count_event_s;

    typedef struct packed {
        logic in_token;
        logic [2:0] endpoint;
        logic stalled;
    } in_token_s;

    typedef struct packed {
        logic send_data;
        logic send_nak;
        logic [2:0] endpoint;
    } in_answer_s;

endpackage

`default_nettype wire

// File: usb_endpoint_fifo_control.sv
// endpoint valid-size counters, direction and transmit-arm registers behind AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

// How it works
// - counters are 10-bit read-only; high byte shows bits 9:8, rest zero
// - reset lows: setup/ep0-out 00, ep0-in/ep1/ep2 10, ep3 08; highs 00
// - direction register holds endpoints 1..5; IN answers follow it for 1..3 and 5, never endpoints 0 or 4
// - direction register resets to 3c on system or function soft reset
// - direction bits 6..2 map endpoints 5..1; one means host input
// - endpoint 2 direction bit: zero output, one input
// - reserved direction bits 7,1,0 and arm bits 7,6,0 read zero
// - IN token on unstalled input endpoint: send data, or NAK if none
// - arm after filling fifo; arming updates the counter, enabling send
// - ep4 arm readies ram fifo; next IN token triggers pre-read
// - arming with empty fifo sends a zero-length packet on next IN
// - arm bits accept only ones; zeros ignored; read back zero
// - arm bits 5..1 map ep4, ep3, ep2, ep1, ep0 input
// - ep2 arm updates its counter only while ep2 is host input
// - ep0-in, ep1, ep3 arms update their own fifo counters
// - input counter drops by bytes written at arm, rises on host ack
// - low-byte read latches high byte; high read returns latch
// - SETUP token forces setup/ep0-out to 0000 and ep0-in to 0010
module usb_endpoint_fifo_control #(
    parameter int addr_width = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [addr_width-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [addr_width-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // function core side
    input wire logic [9:0] cpu_write_bytes [usb_ep_pkg::num_counters],
    input wire usb_ep_pkg::count_event_s core_event,
    input wire logic setup_token,
    input wire usb_ep_pkg::in_token_s in_token,
    output usb_ep_pkg::in_answer_s in_answer,
    output logic [7:0] endpoint_direction_out,
    output logic [7:0] tx_arm_pulse,
    output logic ep4_prefetch
);
    localparam int num_counters = usb_ep_pkg::num_counters;

    // ========================================
    // state
    typedef struct packed {
        usb_ep_pkg::bus_state_e bus;
        logic [31:0] rdata;
        logic [1:0] resp;
        logic aw_held;
        logic [addr_width-1:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [num_counters-1:0][9:0] count;
        logic [num_counters-1:0][1:0] high_latch;
        logic [7:0] direction;
        logic [7:0] arm;
        logic [5:0] pending;
        logic ep4_armed;
        logic ep4_prefetch;
        usb_ep_pkg::in_answer_s answer;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic [9:0] reset_count(input int i);
        case (i)
            usb_ep_pkg::idx_setup_rx: reset_count = usb_ep_pkg::setup_rx_count_reset;
            usb_ep_pkg::idx_ep0_out: reset_count = usb_ep_pkg::ep0_out_count_reset;
            usb_ep_pkg::idx_ep0_in: reset_count = usb_ep_pkg::ep0_in_count_reset;
            usb_ep_pkg::idx_ep1: reset_count = usb_ep_pkg::ep1_count_reset;
            usb_ep_pkg::idx_ep2: reset_count = usb_ep_pkg::ep2_count_reset;
            default: reset_count = usb_ep_pkg::ep3_count_reset;
        endcase
    endfunction

    function automatic state_s reset_state();
        state_s s;
        s = '0;
        s.bus = usb_ep_pkg::bus_idle;
        for (int i = 0; i < num_counters; i++) begin
            s.count[i] = reset_count(i);
        end
        s.direction = usb_ep_pkg::endpoint_direction_reset;
        return s;
    endfunction

    // map register address to counter index; 7 when not a counter
    function automatic logic [2:0] count_index(input logic [addr_width-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        if (o < usb_ep_pkg::endpoint_direction_addr && o[1:0] == 2'b00) begin
            count_index = 3'(o[7:3]);
        end else begin
            count_index = 3'h7;
        end
    endfunction

    // endpoint number of the in-token to counter index, 7 for none
    function automatic logic [2:0] in_index(input logic [2:0] ep);
        case (ep)
            3'h0: in_index = 3'(usb_ep_pkg::idx_ep0_in);
            3'h1: in_index = 3'(usb_ep_pkg::idx_ep1);
            3'h2: in_index = 3'(usb_ep_pkg::idx_ep2);
            3'h3: in_index = 3'(usb_ep_pkg::idx_ep3);
            default: in_index = 3'h7;
        endcase
    endfunction

    logic soft_reset;
    logic [2:0] ri;
    logic [2:0] ti;
    logic [7:0] wbyte;
    logic wr_go;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic is_input;
    logic has_data;

    // ========================================
    // next state
    always_comb begin
        next_st = st;
        soft_reset = 1'b0;
        wbyte = 8'h00;
        ri = 3'h7;
        ti = 3'h7;
        raddr = 8'(s_axi_araddr);
        waddr = 8'(st.awaddr);
        is_input = 1'b0;
        has_data = 1'b0;
        next_st.arm = 8'h00;
        next_st.answer = '0;

        // capture write channels in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
            waddr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        wr_go = st.bus == usb_ep_pkg::bus_idle && next_st.aw_held && next_st.w_held && !s_axi_arvalid;
        wbyte = next_st.wstrb[0] ? next_st.wdata[7:0] : 8'h00;

        case (st.bus)
            usb_ep_pkg::bus_idle: begin
                if (s_axi_arvalid) begin
                    next_st.bus = usb_ep_pkg::bus_rresp;
                    next_st.resp = 2'b00;
                    next_st.rdata = 32'h0000_0000;
                    ri = count_index(s_axi_araddr);
                    if (ri < 3'(num_counters)) begin
                        if (raddr[2]) begin
                            next_st.rdata[1:0] = st.high_latch[ri];
                        end else begin
                            next_st.rdata[7:0] = st.count[ri][7:0];
                            next_st.high_latch[ri] = st.count[ri][9:8];
                        end
                    end else if (raddr == usb_ep_pkg::endpoint_direction_addr) begin
                        next_st.rdata[7:0] = st.direction;
                    end else if (raddr == usb_ep_pkg::packet_tx_arm_addr ||
                                 raddr == usb_ep_pkg::fn_control_addr) begin
                        next_st.rdata = 32'h0000_0000;
                    end else begin
                        next_st.resp = 2'b10;
                    end
                end else if (wr_go) begin
                    next_st.bus = usb_ep_pkg::bus_wresp;
                    next_st.aw_held = 1'b0;
                    next_st.w_held = 1'b0;
                    next_st.resp = 2'b00;
                    if (waddr == usb_ep_pkg::endpoint_direction_addr) begin
                        next_st.direction = wbyte & usb_ep_pkg::endpoint_direction_mask;
                    end else if (waddr == usb_ep_pkg::packet_tx_arm_addr) begin
                        next_st.arm = wbyte & usb_ep_pkg::packet_tx_arm_mask;
                    end else if (waddr == usb_ep_pkg::fn_control_addr) begin
                        soft_reset = wbyte[usb_ep_pkg::fn_soft_reset_bit];
                    end else if (count_index(next_st.awaddr) == 3'h7) begin
                        next_st.resp = 2'b10;
                    end
                end
            end
            usb_ep_pkg::bus_wresp: begin
                if (s_axi_bready) begin
                    next_st.bus = usb_ep_pkg::bus_idle;
                end
            end
            usb_ep_pkg::bus_rresp: begin
                if (s_axi_rready) begin
                    next_st.bus = usb_ep_pkg::bus_idle;
                end
            end
            default: next_st.bus = usb_ep_pkg::bus_idle;
        endcase

        // arming: counter drops by bytes the cpu wrote
        if (st.arm[usb_ep_pkg::ep0_in_tx_arm_bit]) begin
            next_st.count[usb_ep_pkg::idx_ep0_in] =
                st.count[usb_ep_pkg::idx_ep0_in] - cpu_write_bytes[usb_ep_pkg::idx_ep0_in];
            next_st.pending[usb_ep_pkg::idx_ep0_in] = 1'b1;
        end
        if (st.arm[usb_ep_pkg::ep1_tx_arm_bit]) begin
            next_st.count[usb_ep_pkg::idx_ep1] =
                st.count[usb_ep_pkg::idx_ep1] - cpu_write_bytes[usb_ep_pkg::idx_ep1];
            next_st.pending[usb_ep_pkg::idx_ep1] = 1'b1;
        end
        if (st.arm[usb_ep_pkg::ep2_tx_arm_bit] && st.direction[usb_ep_pkg::ep2_direction_bit]) begin
            next_st.count[usb_ep_pkg::idx_ep2] =
                st.count[usb_ep_pkg::idx_ep2] - cpu_write_bytes[usb_ep_pkg::idx_ep2];
            next_st.pending[usb_ep_pkg::idx_ep2] = 1'b1;
        end
        if (st.arm[usb_ep_pkg::ep3_tx_arm_bit]) begin
            next_st.count[usb_ep_pkg::idx_ep3] =
                st.count[usb_ep_pkg::idx_ep3] - cpu_write_bytes[usb_ep_pkg::idx_ep3];
            next_st.pending[usb_ep_pkg::idx_ep3] = 1'b1;
        end
        if (st.arm[usb_ep_pkg::ep4_tx_arm_bit]) begin
            next_st.ep4_armed = 1'b1;
        end

        // core events: host ack adds bytes back, output receive adds bytes
        if (core_event.valid && core_event.index < 3'(num_counters)) begin
            next_st.count[core_event.index] = next_st.count[core_event.index] + core_event.bytes;
        end

        // in token answer
        next_st.ep4_prefetch = 1'b0;
        if (in_token.in_token && !in_token.stalled) begin
            ti = in_index(in_token.endpoint);
            // direction bit n+1 belongs to endpoint n
            is_input = in_token.endpoint == 3'h0 || in_token.endpoint == 3'h4 ||
                       st.direction[3'(in_token.endpoint + 3'h1)];
            if (in_token.endpoint == 3'h4) begin
                has_data = st.ep4_armed;
                // a fresh arm in the same cycle wins over the consume
                next_st.ep4_armed = st.arm[usb_ep_pkg::ep4_tx_arm_bit];
                next_st.ep4_prefetch = st.ep4_armed;
            end else if (ti < 3'(num_counters)) begin
                has_data = st.pending[ti];
                // arm bit of counter ti is ti-1; a same-cycle arm keeps it set
                next_st.pending[ti] = st.arm[ti - 3'h1] &&
                    (ti != 3'(usb_ep_pkg::idx_ep2) || st.direction[usb_ep_pkg::ep2_direction_bit]);
            end
            if (is_input) begin
                next_st.answer.send_data = has_data;
                next_st.answer.send_nak = !has_data;
                next_st.answer.endpoint = in_token.endpoint;
            end
        end

        if (setup_token) begin
            next_st.count[usb_ep_pkg::idx_setup_rx] = 10'h000;
            next_st.count[usb_ep_pkg::idx_ep0_out] = 10'h000;
            next_st.count[usb_ep_pkg::idx_ep0_in] = usb_ep_pkg::setup_ep0_in_count;
            next_st.pending[usb_ep_pkg::idx_ep0_in] = 1'b0;
        end

        if (soft_reset) begin
            next_st = reset_state();
            next_st.bus = usb_ep_pkg::bus_wresp;
            next_st.resp = 2'b00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= reset_state();
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // outputs
    assign s_axi_awready = st.bus == usb_ep_pkg::bus_idle && !st.aw_held;
    assign s_axi_wready = st.bus == usb_ep_pkg::bus_idle && !st.w_held;
    assign s_axi_arready = st.bus == usb_ep_pkg::bus_idle;
    assign s_axi_bvalid = st.bus == usb_ep_pkg::bus_wresp;
    assign s_axi_bresp = st.resp;
    assign s_axi_rvalid = st.bus == usb_ep_pkg::bus_rresp;
    assign s_axi_rresp = st.resp;
    assign s_axi_rdata = st.rdata;
    assign in_answer = st.answer;
    assign endpoint_direction_out = st.direction;
    assign tx_arm_pulse = st.arm;
    assign ep4_prefetch = st.ep4_prefetch;

    // ========================================
    // assertions
    property p_direction_reserved;
        @(posedge aclk) disable iff (!aresetn)
        (st.direction & ~usb_ep_pkg::endpoint_direction_mask) == 8'h00;
    endproperty
    a_direction_reserved: assert property (p_direction_reserved) else $error("reserved direction bit set");

    property p_arm_pulse;
        @(posedge aclk) disable iff (!aresetn)
        st.arm != 8'h00 |=> st.arm == 8'h00 || $past(wr_go);
    endproperty
    a_arm_pulse: assert property (p_arm_pulse) else $error("arm bit held");

    property p_reset_direction;
        @(posedge aclk) !aresetn |=> st.direction == usb_ep_pkg::endpoint_direction_reset;
    endproperty
    a_reset_direction: assert property (p_reset_direction) else $error("direction reset wrong");

    property p_reset_ep3;
        @(posedge aclk) !aresetn |=> st.count[usb_ep_pkg::idx_ep3] == usb_ep_pkg::ep3_count_reset &&
            st.count[usb_ep_pkg::idx_ep0_in] == usb_ep_pkg::ep0_in_count_reset;
    endproperty
    a_reset_ep3: assert property (p_reset_ep3) else $error("counter reset wrong");

    property p_setup_forces;
        @(posedge aclk) disable iff (!aresetn)
        setup_token && !soft_reset |=> st.count[0] == 10'h000 && st.count[2] == 10'h010;
    endproperty
    a_setup_forces: assert property (p_setup_forces) else $error("setup did not force counters");

    property p_in_answer;
        @(posedge aclk) disable iff (!aresetn)
        in_token.in_token && !in_token.stalled && in_token.endpoint == 3'h1 && !soft_reset
        |=> in_answer.send_data != in_answer.send_nak;
    endproperty
    a_in_answer: assert property (p_in_answer) else $error("no answer to in token");

    property p_ep2_output_hold;
        @(posedge aclk) disable iff (!aresetn)
        st.arm[3] && !st.direction[3] && !core_event.valid && !soft_reset |=> $stable(st.count[4]);
    endproperty
    a_ep2_output_hold: assert property (p_ep2_output_hold) else $error("ep2 counter moved in output");

    property p_arm_reads_zero;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && $past(raddr) == usb_ep_pkg::packet_tx_arm_addr && $rose(s_axi_rvalid)
        |-> s_axi_rdata == 32'h0;
    endproperty
    a_arm_reads_zero: assert property (p_arm_reads_zero) else $error("arm register read nonzero");

    property p_high_byte;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && (s_axi_rresp == 2'b00 || s_axi_rdata == 32'h0);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("upper read bits nonzero");

    property p_prefetch_armed;
        @(posedge aclk) disable iff (!aresetn)
        in_token.in_token && !in_token.stalled && in_token.endpoint == 3'h4 && st.ep4_armed && !soft_reset
        |=> ep4_prefetch && in_answer.send_data;
    endproperty
    a_prefetch_armed: assert property (p_prefetch_armed) else $error("armed ep4 in token not prefetched");

    c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
    c_nak: cover property (@(posedge aclk) in_answer.send_nak);
    c_send: cover property (@(posedge aclk) in_answer.send_data);
    c_prefetch: cover property (@(posedge aclk) ep4_prefetch);

endmodule // usb_endpoint_fifo_control

`default_nettype wire

// File: usb_core_model.sv
// far-side model of the usb function core: tokens and host acknowledgements
`timescale 1ns/1ps
`default_nettype none
module usb_core_model (
    // clock
    input wire logic aclk,
    // toward the block
    output var usb_ep_pkg::count_event_s core_event,
    output var logic setup_token,
    output var usb_ep_pkg::in_token_s in_token
);
    initial begin
        core_event = '0;
        setup_token = 1'h0;
        in_token = '0;
    end
    // ========================================
    // one-cycle pulses, launched just after an edge
    task automatic send_in(input logic [2:0] ep, input logic stall);
        @(posedge aclk);
        in_token <= '{1'h1, ep, stall};
        @(posedge aclk);
        in_token <= '0;
    endtask
    task automatic host_ack(input logic [2:0] idx, input logic [9:0] n);
        @(posedge aclk);
        core_event <= '{1'h1, idx, n};
        @(posedge aclk);
        core_event <= '0;
    endtask
    task automatic setup_pulse();
        @(posedge aclk);
        setup_token <= 1'h1;
        @(posedge aclk);
        setup_token <= 1'h0;
    endtask
endmodule // usb_core_model
`default_nettype wire

// File: test_usb_endpoint_fifo_control.sv
// self-checking bench for the endpoint counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module test_usb_endpoint_fifo_control;
    // ========================================
    // signals
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'h0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'h0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'h0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'h0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'h0;
    logic [9:0] wb [usb_ep_pkg::num_counters] = '{default: 10'h0};
    logic [7:0] rst_low [6] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h08};
    usb_ep_pkg::count_event_s core_event;
    logic setup_token;
    usb_ep_pkg::in_token_s in_token;
    usb_ep_pkg::in_answer_s in_answer;
    logic [7:0] dir_out;
    logic [7:0] arm_pulse;
    logic [7:0] pulse_seen;
    logic prefetch;
    logic [1:0] resp_seen;
    logic [31:0] data_seen;
    int err_total = 0;
    int check_count = 0;
    always #5 aclk = ~aclk;
    usb_endpoint_fifo_control #(.addr_width(8)) usb_endpoint_fifo_control_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_write_bytes(wb), .core_event(core_event), .setup_token(setup_token), .in_token(in_token),
        .in_answer(in_answer), .endpoint_direction_out(dir_out), .tx_arm_pulse(arm_pulse), .ep4_prefetch(prefetch)
    );
    usb_core_model usb_core_model_i (
        .aclk(aclk), .core_event(core_event), .setup_token(setup_token), .in_token(in_token)
    );
    // ========================================
    // verdict and bus tasks
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic stuck(input int n);
        if (n >= 40) begin
            err_total++;
            wrap_up();
        end
    endtask
    // ready is looked at mid-cycle, where it already holds its edge value
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        logic aw_hit;
        logic w_hit;
        logic b_hit;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            resp_seen = bresp;
            pulse_seen = arm_pulse;
            @(posedge aclk);
            if (aw_hit)
                awvalid <= 1'h0;
            if (w_hit)
                wvalid <= 1'h0;
            if (b_hit)
                break;
        end
        bready <= 1'h0;
        stuck(n);
        `CHK($sformatf("bresp %h", a), 2'h0, resp_seen)
    endtask
    task automatic axr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ar_hit;
        logic r_hit;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            resp_seen = rresp;
            data_seen = rdata;
            @(posedge aclk);
            if (ar_hit)
                arvalid <= 1'h0;
            if (r_hit)
                break;
        end
        rready <= 1'h0;
        stuck(n);
        `CHK($sformatf("rresp %h", a), er, resp_seen)
        if (er == 2'h0)
            `CHK($sformatf("reg %h", a), {24'h0, e}, data_seen)
    endtask
    task automatic inchk(input logic [2:0] ep, input logic data);
        usb_core_model_i.send_in(ep, 1'h0);
        #1;
        `CHK("in_answer", {data, ~data, ep}, in_answer)
        `CHK("ep4_prefetch", (ep == 3'h4) && data, prefetch)
    endtask
    // ========================================
    // main sequence
    initial begin
        int i;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 6; i++) begin
            axr(8'(8 * i), rst_low[i], 2'h0);
            axr(8'(8 * i + 4), 8'h00, 2'h0);
        end
        axr(8'h30, 8'h3c, 2'h0);
        axr(8'h34, 8'h00, 2'h0);
        axr(8'h3c, 8'h00, 2'h2);
        // ep2 to host output, reserved bits written as ones
        axw(8'h30, 8'hb7);
        axr(8'h30, 8'h34, 2'h0);
        `CHK("direction_out", 8'h34, dir_out)
        wb[4] <= 10'h002;
        axw(8'h34, 8'h08);
        axr(8'h20, 8'h10, 2'h0);
        axw(8'h38, 8'h01);
        axr(8'h30, 8'h3c, 2'h0);
        axw(8'h20, 8'hff);
        axr(8'h20, 8'h10, 2'h0);
        wb[2] <= 10'h004;
        wb[3] <= 10'h003;
        axw(8'h34, 8'hff);
        `CHK("tx_arm_pulse", 8'h3e, pulse_seen)
        axr(8'h34, 8'h00, 2'h0);
        axr(8'h10, 8'h0c, 2'h0);
        axr(8'h18, 8'h0d, 2'h0);
        axr(8'h20, 8'h0e, 2'h0);
        axr(8'h28, 8'h08, 2'h0);
        inchk(3'h1, 1'h1);
        inchk(3'h1, 1'h0);
        usb_core_model_i.send_in(3'h3, 1'h1);
        #1;
        `CHK("in_stalled", 5'h00, in_answer)
        usb_core_model_i.send_in(3'h5, 1'h0);
        #1;
        `CHK("in_ep5_output", 5'h00, in_answer)
        inchk(3'h3, 1'h1);
        inchk(3'h4, 1'h1);
        inchk(3'h4, 1'h0);
        inchk(3'h0, 1'h1);
        inchk(3'h2, 1'h1);
        usb_core_model_i.host_ack(3'h3, 10'h003);
        axr(8'h18, 8'h10, 2'h0);
        usb_core_model_i.host_ack(3'h4, 10'h200);
        axr(8'h20, 8'h0e, 2'h0);
        usb_core_model_i.host_ack(3'h4, 10'h100);
        axr(8'h24, 8'h02, 2'h0);
        axr(8'h20, 8'h0e, 2'h0);
        axr(8'h24, 8'h03, 2'h0);
        usb_core_model_i.host_ack(3'h1, 10'h005);
        axr(8'h08, 8'h05, 2'h0);
        usb_core_model_i.setup_pulse();
        axr(8'h08, 8'h00, 2'h0);
        axr(8'h10, 8'h10, 2'h0);
        wrap_up();
    end
endmodule // test_usb_endpoint_fifo_control
`default_nettype wire
